// ===== rtl/modmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module modmc_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External modulation inputs
    input wire logic [modmc_pkg::SMP_W-1:0] ext_mod_sample,
    input wire logic ext_trig_in,
    input wire logic carrier_sync_in,
    // Modulation outputs
    output logic mod_active,
    output logic conflict,
    output logic hop_sel,
    output logic [31:0] freq_add,
    output logic [31:0] phase_add,
    output logic [31:0] amp_gain,
    output logic [31:0] dc_add,
    output logic [31:0] pw_add,
    // Sync and sub output
    output logic sync_out,
    output logic [modmc_pkg::SMP_W-1:0] sub_wave
);
    import modmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Settings
    logic mode_r, src_r, extadd_r, pol_r;
    modmc_type_t type_r, type_new;
    modmc_shape_t internal_mod_shape_r, shape_new, eff_shape;
    modmc_sync_t sync_port_select_r, sync_new;
    modmc_state_t st_r, st_nxt;
    logic [31:0] width_r, internal_mod_rate_r, tcfg_r, ctrl_word, rd_nxt;
    logic acc_ph, wr, sel_ctrl, sel_rate, sel_cmd, sel_tcfg, sel_tdata, mapped;
    logic keying, keying_new, shape_bad, sync_bad, rate_bad, start_p, stop_p;
    logic trig_m_r, trig_s_r, key, bad_cfg;
    logic ld_busy, tbl_ok, mem_we;
    logic [TBL_AW-1:0] mem_addr, wg_idx;
    logic [SMP_W-1:0] mem_data, tbl_q, wave, csmp;
    logic [SMP_W-1:0] tbl_mem [1 << TBL_AW];
    logic sq_hi, marker;
    logic signed [48:0] prod;
    logic [31:0] term;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign acc_ph = psel && penable;
    assign pready = !ld_busy;
    assign wr = acc_ph && pwrite && pready;
    assign sel_ctrl = paddr == OFF_CTRL;
    assign sel_rate = paddr == OFF_RATE;
    assign sel_cmd = paddr == OFF_CMD;
    assign sel_tcfg = paddr == OFF_TCFG;
    assign sel_tdata = paddr == OFF_TDATA;
    assign mapped = sel_ctrl || sel_rate || sel_cmd || sel_tcfg || sel_tdata
        || paddr == OFF_WIDTH || paddr == OFF_STATUS;
    assign type_new = modmc_type_t'(pwdata[CT_TYPE +: 3]);
    assign shape_new = modmc_shape_t'(pwdata[CT_SHAPE +: 3]);
    assign sync_new = modmc_sync_t'(pwdata[CT_SYNC +: 2]);
    assign keying = type_r == MT_FSK || type_r == MT_PSK;
    assign keying_new = type_new == MT_FSK || type_new == MT_PSK;
    assign eff_shape = keying ? SH_SQUARE : internal_mod_shape_r;
    assign shape_bad = shape_new == SH_ILLEGAL || (keying_new && shape_new != SH_SQUARE);
    assign sync_bad = sync_new == SYNC_ILLEGAL || (keying_new && sync_new == SYNC_WAVE);
    assign rate_bad = eff_shape == SH_NOISE;
    assign pslverr = acc_ph && (!mapped || (pwrite && ((sel_ctrl && (shape_bad || sync_bad))
        || (sel_rate && rate_bad))));
    assign start_p = wr && sel_cmd && pwdata[CMD_START];
    assign stop_p = wr && sel_cmd && pwdata[CMD_STOP];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 1'b0;
            type_r <= MT_FM;
            src_r <= 1'b0;
            internal_mod_shape_r <= SH_SINE;
            extadd_r <= 1'b0;
            pol_r <= 1'b1;
            sync_port_select_r <= SYNC_CARRIER;
        end else if (wr && sel_ctrl) begin
            mode_r <= pwdata[CT_MODE];
            type_r <= type_new;
            src_r <= pwdata[CT_SRC];
            extadd_r <= pwdata[CT_EXTADD];
            pol_r <= pwdata[CT_POL];
            if (keying_new) begin
                internal_mod_shape_r <= SH_SQUARE;
            end else if (!shape_bad) begin
                internal_mod_shape_r <= shape_new;
            end
            if (!sync_bad) begin
                sync_port_select_r <= sync_new;
            end else if (keying_new && sync_port_select_r == SYNC_WAVE) begin
                sync_port_select_r <= SYNC_CARRIER;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_r <= WIDTH_RST;
            internal_mod_rate_r <= RATE_RST;
            tcfg_r <= '0;
        end else if (wr) begin
            if (paddr == OFF_WIDTH) begin
                width_r <= pwdata;
            end
            if (sel_rate && !rate_bad) begin
                internal_mod_rate_r <= pwdata;
            end
            if (sel_tcfg) begin
                tcfg_r <= pwdata;
            end
        end
    end

    always_comb begin
        ctrl_word = '0;
        ctrl_word[CT_MODE] = mode_r;
        ctrl_word[CT_TYPE +: 3] = type_r;
        ctrl_word[CT_SRC] = src_r;
        ctrl_word[CT_SHAPE +: 3] = eff_shape;
        ctrl_word[CT_EXTADD] = extadd_r;
        ctrl_word[CT_POL] = pol_r;
        ctrl_word[CT_SYNC +: 2] = sync_port_select_r;
        unique case (paddr)
            OFF_CTRL: rd_nxt = ctrl_word;
            OFF_WIDTH: rd_nxt = width_r;
            OFF_RATE: rd_nxt = internal_mod_rate_r;
            OFF_STATUS: rd_nxt = {27'h0, tbl_ok, st_r == S_WAIT, st_r == S_PAUSE,
                st_r == S_RUN, mode_r};
            OFF_TCFG: rd_nxt = tcfg_r;
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User table
    modmc_table_loader u_loader (
        .pclk(pclk),
        .presetn(presetn),
        .cfg_we(wr && sel_tcfg),
        .cfg_point(pwdata[TC_POINT]),
        .cfg_len(pwdata[TC_LEN +: 24]),
        .dat_we(wr && sel_tdata),
        .dat_idx(pwdata[TD_IDX +: TBL_AW]),
        .dat_val(pwdata[SMP_W-1:0]),
        .busy(ld_busy),
        .loaded(tbl_ok),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_data(mem_data)
    );

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            tbl_mem[mem_addr] <= mem_data;
        end
        tbl_q <= tbl_mem[wg_idx];
    end

    modmc_wave_gen u_wave (
        .pclk(pclk),
        .presetn(presetn),
        .rate(internal_mod_rate_r),
        .shape(eff_shape),
        .tbl_q(tbl_q),
        .tbl_idx(wg_idx),
        .sample(wave),
        .sq_hi(sq_hi),
        .marker(marker)
    );

    ////////////////////////////////////////////////////////////////////////
    // Run control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_m_r <= 1'b0;
            trig_s_r <= 1'b0;
        end else begin
            trig_m_r <= ext_trig_in;
            trig_s_r <= trig_m_r;
        end
    end

    assign bad_cfg = (src_r && !keying && extadd_r)
        || (!src_r && eff_shape == USER_TABLE_WAVE && !tbl_ok)
        || (!src_r && eff_shape != SH_NOISE && internal_mod_rate_r == '0);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            S_OFF: st_nxt = bad_cfg ? S_WAIT : S_RUN;
            S_WAIT: st_nxt = stop_p ? S_PAUSE : (bad_cfg ? S_WAIT : S_RUN);
            S_RUN: st_nxt = stop_p ? S_PAUSE : (bad_cfg ? S_WAIT : S_RUN);
            S_PAUSE: st_nxt = !start_p ? S_PAUSE : (bad_cfg ? S_WAIT : S_RUN);
        endcase
        if (!mode_r) begin
            st_nxt = S_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulation terms
    assign key = src_r ? (trig_s_r ~^ pol_r) : sq_hi;
    assign csmp = src_r ? (extadd_r ? '0 : ext_mod_sample) : wave;
    assign prod = $signed(csmp) * $signed({1'b0, width_r});
    assign term = prod[46:15];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_active <= 1'b0;
            conflict <= 1'b0;
            hop_sel <= 1'b0;
            freq_add <= '0;
            phase_add <= '0;
            amp_gain <= FULL_GAIN;
            dc_add <= '0;
            pw_add <= '0;
        end else begin
            mod_active <= st_r == S_RUN;
            conflict <= st_r == S_WAIT;
            hop_sel <= st_r == S_RUN && type_r == MT_FSK && key;
            freq_add <= (st_r == S_RUN && type_r == MT_FM) ? term : '0;
            phase_add <= '0;
            amp_gain <= FULL_GAIN;
            dc_add <= (st_r == S_RUN && type_r == MT_OFFSET_MODULATION) ? term : '0;
            pw_add <= (st_r == S_RUN && type_r == MT_PWM) ? term : '0;
            if (st_r == S_RUN && type_r == MT_PM) begin
                phase_add <= term;
            end else if (st_r == S_RUN && type_r == MT_PSK && key) begin
                phase_add <= width_r;
            end
            if (st_r == S_RUN && type_r == MT_AM) begin
                amp_gain <= HALF_GAIN + {term[31], term[31:1]};
            end else if (st_r == S_RUN && type_r == MT_AM_SC) begin
                amp_gain <= {term[31], term[31:1]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= 1'b0;
            sub_wave <= '0;
        end else begin
            sync_out <= (sync_port_select_r == SYNC_CARRIER) ? carrier_sync_in
                : (sync_port_select_r == MOD_PHASE_MARKER) && marker;
            sub_wave <= (sync_port_select_r == SYNC_WAVE) ? wave : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    amsc_no_carrier_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_RUN && type_r == MT_AM_SC && csmp == '0 |=> amp_gain == '0)
        else $error("suppressed carrier gain not zero");
    rate_refused_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && sel_rate && eff_shape == SH_NOISE |=> $stable(internal_mod_rate_r))
        else $error("rate taken during noise");
    keying_square_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        keying |-> internal_mod_shape_r == SH_SQUARE && sync_port_select_r != SYNC_WAVE)
        else $error("keying shape not square");
    ext_add_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_r && extadd_r && !keying |-> csmp == '0 ##1 st_r != S_RUN)
        else $error("external modulation with addition");
    auto_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_OFF && mode_r && !bad_cfg |=> st_r == S_RUN ##1 mod_active)
        else $error("no automatic start");
    conflict_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_RUN && mode_r && bad_cfg && !stop_p |=> st_r == S_WAIT ##1 conflict)
        else $error("conflict not raised");
    stop_pause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_RUN && mode_r && stop_p |=> st_r == S_PAUSE ##1 freq_add == '0
        && amp_gain == FULL_GAIN && !hop_sel)
        else $error("stop did not pass carrier");
    start_resume_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_PAUSE && mode_r && start_p && !bad_cfg |=> st_r == S_RUN)
        else $error("start did not resume");
    fsk_polarity_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == S_RUN && type_r == MT_FSK && src_r |=> hop_sel == $past(trig_s_r ~^ pol_r))
        else $error("hop select wrong");
    noise_marker_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sync_port_select_r == MOD_PHASE_MARKER && eff_shape == SH_NOISE) [*3] |=> !sync_out)
        else $error("marker during noise");
endmodule : modmc_ctrl
`default_nettype wire

// ===== rtl/modmc_pkg.sv
package modmc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_WIDTH = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_TCFG = 8'h14;
    localparam logic [7:0] OFF_TDATA = 8'h18;
    localparam int CT_MODE = 0;
    localparam int CT_TYPE = 1;
    localparam int CT_SRC = 4;
    localparam int CT_SHAPE = 5;
    localparam int CT_EXTADD = 8;
    localparam int CT_POL = 9;
    localparam int CT_SYNC = 10;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int TC_POINT = 0;
    localparam int TC_LEN = 8;
    localparam int TD_IDX = 16;
    localparam logic [31:0] WIDTH_RST = 32'h0000_0000;
    localparam logic [31:0] RATE_RST = 32'h0000_0000;
    localparam logic [31:0] FULL_GAIN = 32'h0000_8000;
    localparam logic [31:0] HALF_GAIN = 32'h0000_4000;
    localparam logic [15:0] SQ_HIGH = 16'h7FFF;
    localparam logic [15:0] SQ_LOW = 16'h8001;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam int TBL_AW = 12;
    localparam int SMP_W = 16;
    typedef enum logic [2:0] {
        MT_FM, MT_FSK, MT_PM, MT_PSK, MT_AM, MT_AM_SC, MT_OFFSET_MODULATION, MT_PWM
    } modmc_type_t;
    typedef enum logic [2:0] {
        SH_SINE, SH_SQUARE, SH_TRIANGLE, RISING_SAWTOOTH, FALLING_SAWTOOTH,
        SH_NOISE, USER_TABLE_WAVE, SH_ILLEGAL
    } modmc_shape_t;
    typedef enum logic [1:0] {
        SYNC_CARRIER, MOD_PHASE_MARKER, SYNC_WAVE, SYNC_ILLEGAL
    } modmc_sync_t;
    typedef enum logic [1:0] {S_OFF, S_WAIT, S_RUN, S_PAUSE} modmc_state_t;
endpackage : modmc_pkg

// ===== rtl/modmc_table_loader.sv
`timescale 1ns/1ps
`default_nettype none
module modmc_table_loader #(
    parameter int AW = modmc_pkg::TBL_AW,
    parameter int DW = modmc_pkg::SMP_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Load requests
    input wire logic cfg_we,
    input wire logic cfg_point,
    input wire logic [23:0] cfg_len,
    input wire logic dat_we,
    input wire logic [AW-1:0] dat_idx,
    input wire logic [DW-1:0] dat_val,
    // Table write port and status
    output logic busy,
    output logic loaded,
    output logic mem_we,
    output logic [AW-1:0] mem_addr,
    output logic [DW-1:0] mem_data
);
    import modmc_pkg::*;
    logic point_r, first_r, fill_r, done_r, raw_take, pt_take;
    logic [AW-1:0] ptr_r, tgt_r;
    logic [11:0] stride_r, skip_r;
    logic [DW-1:0] prev_r, val_r;

    assign raw_take = dat_we && !point_r && !done_r && skip_r == 12'h000;
    assign pt_take = dat_we && point_r && !fill_r && !done_r && (first_r || dat_idx >= ptr_r);
    assign busy = fill_r;
    assign loaded = done_r;
    assign mem_we = raw_take || fill_r;
    assign mem_addr = ptr_r;
    assign mem_data = fill_r ? ((ptr_r == tgt_r) ? val_r : prev_r) : dat_val;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            point_r <= 1'b0;
            first_r <= 1'b1;
            fill_r <= 1'b0;
            done_r <= 1'b0;
            ptr_r <= '0;
            tgt_r <= '0;
            stride_r <= 12'h001;
            skip_r <= 12'h000;
            prev_r <= '0;
            val_r <= '0;
        end else if (cfg_we) begin
            point_r <= cfg_point;
            first_r <= 1'b1;
            fill_r <= 1'b0;
            done_r <= 1'b0;
            ptr_r <= '0;
            skip_r <= 12'h000;
            stride_r <= (cfg_len[23:12] == 12'h000) ? 12'h001 : cfg_len[23:12];
        end else if (dat_we && !point_r && !done_r) begin
            skip_r <= (skip_r == stride_r - 12'h001) ? 12'h000 : skip_r + 12'h001;
            if (raw_take) begin
                ptr_r <= ptr_r + 1'b1;
                done_r <= &ptr_r;
            end
        end else if (pt_take) begin
            tgt_r <= dat_idx;
            val_r <= dat_val;
            fill_r <= 1'b1;
            first_r <= 1'b0;
            if (first_r) begin
                prev_r <= dat_val;
            end
        end else if (fill_r) begin
            ptr_r <= ptr_r + 1'b1;
            if (ptr_r == tgt_r) begin
                fill_r <= 1'b0;
                prev_r <= val_r;
                done_r <= &tgt_r;
            end
        end
    end
endmodule : modmc_table_loader
`default_nettype wire

// ===== rtl/modmc_wave_gen.sv
`timescale 1ns/1ps
`default_nettype none
module modmc_wave_gen #(
    parameter int AW = modmc_pkg::TBL_AW
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Settings
    input wire logic [31:0] rate,
    input wire modmc_pkg::modmc_shape_t shape,
    // Table read
    input wire logic [15:0] tbl_q,
    output logic [AW-1:0] tbl_idx,
    // Waveform
    output logic [15:0] sample,
    output logic sq_hi,
    output logic marker
);
    import modmc_pkg::*;
    logic [31:0] acc_r;
    logic [15:0] lfsr_r, tri_mag, sin_mag, smp_nxt;
    logic [21:0] para;

    assign tbl_idx = acc_r[31 -: AW];
    assign sq_hi = !acc_r[31];
    assign para = {11'h000, acc_r[30:20]} * {11'h000, ~acc_r[30:20]};
    assign sin_mag = {1'b0, para[19:5]};
    assign tri_mag = {1'b0, acc_r[30] ? ~acc_r[29:15] : acc_r[29:15]};

    always_comb begin
        unique case (shape)
            SH_SINE: smp_nxt = acc_r[31] ? 16'h0000 - sin_mag : sin_mag;
            SH_SQUARE: smp_nxt = acc_r[31] ? SQ_LOW : SQ_HIGH;
            SH_TRIANGLE: smp_nxt = acc_r[31] ? 16'h0000 - tri_mag : tri_mag;
            RISING_SAWTOOTH: smp_nxt = acc_r[31:16];
            FALLING_SAWTOOTH: smp_nxt = ~acc_r[31:16];
            SH_NOISE: smp_nxt = lfsr_r;
            default: smp_nxt = tbl_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
            lfsr_r <= LFSR_SEED;
            sample <= '0;
            marker <= 1'b0;
        end else begin
            acc_r <= acc_r + rate;
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            sample <= smp_nxt;
            marker <= !acc_r[31] && shape != SH_NOISE;
        end
    end
endmodule : modmc_wave_gen
`default_nettype wire

// ===== verification/modmc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module modmc_ext_src (
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic key_req,
    input wire logic [15:0] lvl_req,
    // Far-side pins
    output logic trig,
    output logic [15:0] smp
);
    // TTL key level, launched after a clock edge
    always_ff @(posedge pclk) begin
        trig <= key_req;
    end
    // Signed level, 16'h7FFF stands for +1 V
    always_ff @(posedge pclk) begin
        smp <= lvl_req;
    end
endmodule : modmc_ext_src
`default_nettype wire

// ===== verification/modulation_mode_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module modulation_mode_controller_tb;
    import modmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, mod_active, conflict, hop_sel;
    logic key = 1'b0, sync_out, trig;
    logic [7:0] paddr = 8'h00;
    logic [15:0] lvl = 16'h0000, smp, sub_wave;
    logic [31:0] pwdata = 32'h0, prdata, rd, fa, pa, ag, da, pw;
    logic err;
    int n_mismatch = 0, num_checks = 0;
    ////////////////////////////////////////////////////////////
    modmc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_mod_sample(smp), .ext_trig_in(trig), .carrier_sync_in(1'b0),
        .mod_active(mod_active), .conflict(conflict), .hop_sel(hop_sel),
        .freq_add(fa), .phase_add(pa), .amp_gain(ag), .dc_add(da),
        .pw_add(pw), .sync_out(sync_out), .sub_wave(sub_wave));
    modmc_ext_src src (.pclk(pclk), .key_req(key), .lvl_req(lvl),
        .trig(trig), .smp(smp));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 5000; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 5000) begin
            n_mismatch++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_0200);
        chk(ag, FULL_GAIN);
        chk({31'h0, mod_active}, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_start;
        apb(1'b1, OFF_CTRL, 32'h0000_0221);
        wt(3);
        chk({31'h0, conflict}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0009);
        apb(1'b1, OFF_RATE, 32'h0000_0100);
        wt(3);
        chk({31'h0, mod_active}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0000_0621);
        wt(4);
        chk({31'h0, sync_out}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0000_0A21);
        wt(4);
        chk({16'h0, sub_wave}, {16'h0, SQ_HIGH});
        apb(1'b1, OFF_WIDTH, 32'h0000_8000);
        apb(1'b1, OFF_CMD, 32'h0000_0002);
        wt(3);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0005);
        chk(ag, FULL_GAIN);
        chk(fa, 32'h0);
        apb(1'b1, OFF_CMD, 32'h0000_0001);
        wt(3);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        $display("t_start done");
    endtask : t_start
    task automatic t_fsk;
        apb(1'b1, OFF_CTRL, 32'h0000_0213);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_0233);
        key <= 1'b1;
        wt(5);
        chk({31'h0, hop_sel}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0000_0033);
        wt(3);
        chk({31'h0, hop_sel}, 32'h0);
        key <= 1'b0;
        wt(5);
        chk({31'h0, hop_sel}, 32'h1);
        $display("t_fsk done");
    endtask : t_fsk
    task automatic t_refuse;
        apb(1'b1, OFF_CTRL, 32'h0000_06A1);
        apb(1'b1, OFF_RATE, 32'h0000_0040);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, OFF_RATE, 32'h0);
        chk(rd, 32'h0000_0100);
        chk({31'h0, sync_out}, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_am;
        apb(1'b1, OFF_WIDTH, 32'h0000_8000);
        lvl <= 16'h7FFF;
        apb(1'b1, OFF_CTRL, 32'h0000_0219);
        wt(4);
        chk(ag, 32'h0000_7FFF);
        apb(1'b1, OFF_CTRL, 32'h0000_021B);
        wt(4);
        chk(ag, 32'h0000_3FFF);
        apb(1'b1, OFF_CTRL, 32'h0000_0215);
        wt(4);
        chk(pa, 32'h0000_7FFF);
        apb(1'b1, OFF_CTRL, 32'h0000_021D);
        wt(4);
        chk(da, 32'h0000_7FFF);
        chk(pa, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0000_021F);
        wt(4);
        chk(pw, 32'h0000_7FFF);
        apb(1'b1, OFF_CTRL, 32'h0000_031B);
        wt(4);
        chk({31'h0, conflict}, 32'h1);
        chk(ag, FULL_GAIN);
        $display("t_am done");
    endtask : t_am
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_start();
        t_fsk();
        t_refuse();
        t_am();
        conclude();
    end
endmodule : modulation_mode_controller_tb
`default_nettype wire
